// *** rvw_defines.vh ***
`ifndef RVW_DEFINES_VH
`define RVW_DEFINES_VH

// register sub-addresses
`define RVW_ADDR_CTRL        8'h11
`define RVW_ADDR_START       8'h12
`define RVW_ADDR_STOP_LOW    8'h13
`define RVW_ADDR_STOP_HIGH   8'h14
`define RVW_ADDR_SEL_LOW     8'h15
`define RVW_ADDR_SEL_MID     8'h16
`define RVW_ADDR_SEL_HIGH    8'h17

// reset values
`define RVW_RST_CTRL         8'h00
`define RVW_RST_START        8'h7a
`define RVW_RST_STOP_LOW     8'h4a
`define RVW_RST_STOP_HIGH    2'h3
`define RVW_RST_SEL_LOW      8'hfe
`define RVW_RST_SEL_MID      8'h1f
`define RVW_RST_SEL_HIGH     3'h0

// control register fields
`define RVW_CTRL_ODD         0
`define RVW_CTRL_EVEN        1
`define RVW_CTRL_ALL         2

// first masked line of each field and standard
`define RVW_NTSC_ODD_FIRST   10'd9
`define RVW_NTSC_EVEN_FIRST  10'd272
`define RVW_PAL_ODD_FIRST    10'd5
`define RVW_PAL_EVEN_FIRST   10'd318
`define RVW_MASK_BITS        19

// fifo shape
`define RVW_FIFO_WIDTH       8
`define RVW_FIFO_DEPTH       16
`define RVW_FIFO_AW          4

`endif

// *** rvw_fifo_mem.v ***
`timescale 1ns/100ps
`default_nettype none

module rvw_fifo_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             clk_en,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data_reg
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge sys_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data_reg <= mem[rd_addr];
        end
    end
endmodule

`default_nettype wire

// *** rvw_fifo.v ***
`timescale 1ns/100ps
`default_nettype none

module rvw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             resetn,
    input  wire             clk_en,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [AW:0]   wr_ptr_reg;
    reg  [AW:0]   rd_ptr_reg;
    reg           out_valid_reg;
    wire [AW:0]   count = wr_ptr_reg - rd_ptr_reg;
    // the slot just behind rd_ptr holds the word on show, so the queue
    // stops one word short of the memory depth
    wire          full  = (count == DEPTH[AW:0] - 1'b1);
    wire          empty = (count == {(AW+1){1'b0}});
    wire          push  = in_valid && !full;
    // output register refills from a non-empty queue whenever it is empty or being drained
    wire          load  = !empty && (!out_valid_reg || out_ready);
    // a load reads the new head; otherwise the word on show is read again
    wire [AW-1:0] rd_addr = load ? rd_ptr_reg[AW-1:0] : rd_ptr_reg[AW-1:0] - 1'b1;

    assign in_ready  = !full;
    assign out_valid = out_valid_reg;

    rvw_fifo_mem #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .sys_clk     (sys_clk),
        .clk_en      (clk_en),
        .wr_en       (push),
        .wr_addr     (wr_ptr_reg[AW-1:0]),
        .wr_data     (in_data),
        .rd_addr     (rd_addr),
        .rd_data_reg (out_data)
    );

    // out_data holds its word while stalled because its slot is never rewritten
    always @(posedge sys_clk) begin
        if (!resetn) begin
            wr_ptr_reg    <= {(AW+1){1'b0}};
            rd_ptr_reg    <= {(AW+1){1'b0}};
            out_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                rd_ptr_reg    <= rd_ptr_reg + 1'b1;
                out_valid_reg <= 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** rvw_capture.v ***
`timescale 1ns/100ps
`default_nettype none
`include "rvw_defines.vh"

module rvw_capture (
    input  wire       sys_clk,
    input  wire       resetn,
    input  wire       clk_en,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_reg,
    input  wire       hsync_pin,
    input  wire       field_pin,
    input  wire       pal_mode,
    input  wire [9:0] line_number,
    input  wire       sample_strobe,
    input  wire [7:0] sample_data,
    output wire       raw_valid,
    input  wire       raw_ready,
    output wire [7:0] raw_data,
    output reg        raw_overflow_reg
);
    reg [7:0]  ctrl_reg;
    reg [7:0]  start_reg;
    reg [7:0]  stop_low_reg;
    reg [1:0]  stop_high_reg;
    reg [7:0]  sel_low_reg;
    reg [7:0]  sel_mid_reg;
    reg [2:0]  sel_high_reg;

    reg [1:0]  hsync_sync_reg;
    reg [1:0]  field_sync_reg;
    reg        hsync_prev_reg;
    reg        step_phase_reg;
    reg [9:0]  step_count_reg;
    reg        line_enable_reg;
    reg [7:0]  push_data_reg;
    reg        push_valid_reg;

    wire [9:0]  stop_count = {stop_high_reg, stop_low_reg};
    wire [18:0] line_mask  = {sel_high_reg, sel_mid_reg, sel_low_reg};
    wire        hsync_s    = hsync_sync_reg[1];
    wire        even_field = field_sync_reg[1];
    wire        hsync_lead = hsync_s && !hsync_prev_reg;
    wire        in_ready;

    // first line covered by mask bit 0 for the current standard and field
    function [9:0] first_line;
        input pal;
        input even;
        begin
            case ({pal, even})
                2'b00:   first_line = `RVW_NTSC_ODD_FIRST;
                2'b01:   first_line = `RVW_NTSC_EVEN_FIRST;
                2'b10:   first_line = `RVW_PAL_ODD_FIRST;
                default: first_line = `RVW_PAL_EVEN_FIRST;
            endcase
        end
    endfunction

    wire [9:0] first    = first_line(pal_mode, even_field);
    wire [9:0] mask_idx = line_number - first;
    wire       in_range = (line_number >= first) &&
                          (mask_idx < `RVW_MASK_BITS);
    wire       mask_hit = in_range && line_mask[mask_idx[4:0]];
    wire       field_ok = even_field ? ctrl_reg[`RVW_CTRL_EVEN]
                                     : ctrl_reg[`RVW_CTRL_ODD];
    wire       line_ok  = field_ok &&
                          (ctrl_reg[`RVW_CTRL_ALL] || mask_hit);
    wire       in_window = (step_count_reg >= {2'b00, start_reg}) &&
                           (step_count_reg <= stop_count);

    // register writes
    always @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_reg      <= `RVW_RST_CTRL;
            start_reg     <= `RVW_RST_START;
            stop_low_reg  <= `RVW_RST_STOP_LOW;
            stop_high_reg <= `RVW_RST_STOP_HIGH;
            sel_low_reg   <= `RVW_RST_SEL_LOW;
            sel_mid_reg   <= `RVW_RST_SEL_MID;
            sel_high_reg  <= `RVW_RST_SEL_HIGH;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `RVW_ADDR_CTRL:      ctrl_reg      <= {5'h00, reg_wdata[2:0]};
                `RVW_ADDR_START:     start_reg     <= reg_wdata;
                `RVW_ADDR_STOP_LOW:  stop_low_reg  <= reg_wdata;
                `RVW_ADDR_STOP_HIGH: stop_high_reg <= reg_wdata[1:0];
                `RVW_ADDR_SEL_LOW:   sel_low_reg   <= reg_wdata;
                `RVW_ADDR_SEL_MID:   sel_mid_reg   <= reg_wdata;
                `RVW_ADDR_SEL_HIGH:  sel_high_reg  <= reg_wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // register reads; reserved bits and unknown addresses read zero
    always @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata_reg <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                `RVW_ADDR_CTRL:      reg_rdata_reg <= ctrl_reg;
                `RVW_ADDR_START:     reg_rdata_reg <= start_reg;
                `RVW_ADDR_STOP_LOW:  reg_rdata_reg <= stop_low_reg;
                `RVW_ADDR_STOP_HIGH: reg_rdata_reg <= {6'h00, stop_high_reg};
                `RVW_ADDR_SEL_LOW:   reg_rdata_reg <= sel_low_reg;
                `RVW_ADDR_SEL_MID:   reg_rdata_reg <= sel_mid_reg;
                `RVW_ADDR_SEL_HIGH:  reg_rdata_reg <= {5'h00, sel_high_reg};
                default:             reg_rdata_reg <= 8'h00;
            endcase
        end
    end

    // pin synchronisers, then edge detect on the second stage
    always @(posedge sys_clk) begin
        if (!resetn) begin
            hsync_sync_reg <= 2'h0;
            field_sync_reg <= 2'h0;
            hsync_prev_reg <= 1'b0;
        end else if (clk_en) begin
            hsync_sync_reg <= {hsync_sync_reg[0], hsync_pin};
            field_sync_reg <= {field_sync_reg[0], field_pin};
            hsync_prev_reg <= hsync_s;
        end
    end

    // position counter in steps of two fast sample clock periods
    always @(posedge sys_clk) begin
        if (!resetn) begin
            step_phase_reg  <= 1'b0;
            step_count_reg  <= 10'h000;
            line_enable_reg <= 1'b0;
        end else if (clk_en) begin
            if (hsync_lead) begin
                step_phase_reg  <= 1'b0;
                step_count_reg  <= 10'h000;
                line_enable_reg <= line_ok;
            end else if (sample_strobe) begin
                step_phase_reg <= ~step_phase_reg;
                if (step_phase_reg && step_count_reg != 10'h3ff) begin
                    step_count_reg <= step_count_reg + 10'h001;
                end
            end
        end
    end

    // samples inside the window of an enabled line enter the fifo
    always @(posedge sys_clk) begin
        if (!resetn) begin
            push_valid_reg   <= 1'b0;
            push_data_reg    <= 8'h00;
            raw_overflow_reg <= 1'b0;
        end else if (clk_en) begin
            push_valid_reg <= sample_strobe && line_enable_reg &&
                              in_window && !hsync_lead;
            push_data_reg  <= sample_data;
            if (push_valid_reg && !in_ready) begin
                raw_overflow_reg <= 1'b1;
            end else if (hsync_lead) begin
                raw_overflow_reg <= 1'b0;
            end
        end
    end

    rvw_fifo #(
        .WIDTH (`RVW_FIFO_WIDTH),
        .DEPTH (`RVW_FIFO_DEPTH),
        .AW    (`RVW_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .in_valid  (push_valid_reg),
        .in_ready  (in_ready),
        .in_data   (push_data_reg),
        .out_valid (raw_valid),
        .out_ready (raw_ready),
        .out_data  (raw_data)
    );
endmodule

`default_nettype wire

// *** rvcw_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
// host end of the byte stream: backpressure follows the stall request
module rvcw_sink (
    input  wire logic sys_clk,
    input  wire logic stall,
    output var  logic raw_ready
);
    initial raw_ready = 1'h0;
    always @(negedge sys_clk) raw_ready <= !stall;
endmodule
`default_nettype wire

// *** rvcw_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module rvcw_checker (
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_reg,
    input wire logic       raw_valid,
    input wire logic       raw_ready,
    input wire logic [7:0] raw_data
);
    logic [7:0] wd1;
    logic [7:0] wd2;
    wire        w = clk_en && reg_wr;
    wire        r = clk_en && reg_rd;
    wire  [7:0] a = reg_addr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // write data of two edges back, for write-then-read pairs
    always @(posedge sys_clk) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    AST_START_RB:
        assert property (w && a == 8'h12 ##1 r && a == 8'h12 |=> reg_rdata_reg == wd2)
            else $error("start count readback wrong");
    AST_STOPL_RB:
        assert property (w && a == 8'h13 ##1 r && a == 8'h13 |=> reg_rdata_reg == wd2)
            else $error("stop low readback wrong");
    AST_STOPH_RB:
        assert property (w && a == 8'h14 ##1 r && a == 8'h14 |=> reg_rdata_reg == {6'h00, wd2[1:0]})
            else $error("stop high readback wrong");
    AST_SELL_RB:
        assert property (w && a == 8'h15 ##1 r && a == 8'h15 |=> reg_rdata_reg == wd2)
            else $error("mask low readback wrong");
    AST_SELH_RB:
        assert property (w && a == 8'h17 ##1 r && a == 8'h17 |=> reg_rdata_reg == {5'h00, wd2[2:0]})
            else $error("mask high readback wrong");
    AST_RD_HOLD:
        assert property (clk_en && !reg_rd |=> $stable(reg_rdata_reg))
            else $error("read data changed without a read");
    AST_VALID_HOLD:
        assert property (clk_en && raw_valid && !raw_ready |=> raw_valid && $stable(raw_data))
            else $error("stalled byte not held");
    AST_EMPTY_RESET:
        assert property ($rose(resetn) |-> !raw_valid)
            else $error("output valid right after reset");
endmodule
bind rvw_capture rvcw_checker i_rvcw_checker (.sys_clk, .resetn, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_reg, .raw_valid, .raw_ready, .raw_data);
`default_nettype wire

// *** test_raw_vbi_capture_window.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module test_raw_vbi_capture_window;
    logic        sys_clk = 1'h0, resetn = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic        hsync_pin = 1'h0, field_pin = 1'h0, pal_mode = 1'h0, sample_strobe = 1'h0;
    logic        stall = 1'h0, hold = 1'h0, chk_on = 1'h1, rd_d = 1'h0;
    logic        raw_valid, raw_ready, raw_overflow_reg;
    logic [7:0]  reg_addr = '0, reg_wdata = '0, sample_data = '0, reg_rdata_reg, raw_data, ev;
    logic [9:0]  line_number = '0;
    logic [31:0] xs = 32'h5b;
    logic [7:0]  rq[$], dq[$];
    int          err_count = 0, total_checks = 0, st = 2, sp = 4, i;
    localparam logic [7:0] RV[8] = '{8'h00, 8'h7a, 8'h4a, 8'h03, 8'hfe, 8'h1f, 8'h00, 8'h00};
    // {ctrl[2:0], pal, field, line[9:0], captured}
    localparam logic [15:0] TC[16] = '{16'h2012, 16'h2015, 16'h2a22, 16'h2037, 16'h2034,
        16'h4014, 16'h4a20, 16'h4a45, 16'h5a7c, 16'h5aa1, 16'h500c, 16'h700a, 16'h702f,
        16'he0c9, 16'hfb21, 16'h8014};
    rvw_capture i_rvw_capture (.sys_clk, .resetn, .clk_en, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata_reg, .hsync_pin, .field_pin, .pal_mode, .line_number,
        .sample_strobe, .sample_data, .raw_valid, .raw_ready, .raw_data, .raw_overflow_reg);
    rvcw_sink i_rvcw_sink (.sys_clk, .stall, .raw_ready);
    always #4 sys_clk = !sys_clk;
    function automatic logic [7:0] rnd();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs[7:0];
    endfunction
    always @(negedge sys_clk) stall <= hold || rnd() < 8'h40;
    always @(posedge sys_clk) begin
        if (rd_d) begin
            ev = rq.pop_front();
            `CHK(reg_rdata_reg, ev)
        end
        if (raw_valid && raw_ready && chk_on) begin
            ev = dq.pop_front();
            `CHK(raw_data, ev)
        end
        rd_d <= reg_rd;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_rd = 1'h1;
        reg_addr = a;
        rq.push_back(e);
        @(negedge sys_clk);
        reg_rd = 1'h0;
    endtask
    // write, then read the same place back on the next cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
        @(negedge sys_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge sys_clk);
        reg_wr = 1'h0;
        reg_rd = 1'h1;
        rq.push_back(e);
        @(negedge sys_clk);
        reg_rd = 1'h0;
    endtask
    task automatic vline(input logic p, input logic f, input logic [9:0] ln,
                         input logic cap, input int ns);
        int k;
        logic [7:0] d;
        @(negedge sys_clk);
        hsync_pin = 1'h1;
        field_pin = f;
        pal_mode = p;
        line_number = ln;
        repeat (5) @(negedge sys_clk);
        hsync_pin = 1'h0;
        for (k = 0; k < ns; k++) begin
            d = rnd();
            sample_strobe = 1'h1;
            sample_data = d;
            if (cap && k >= 2 * st && k <= 2 * sp + 1) dq.push_back(d);
            @(negedge sys_clk);
            sample_strobe = 1'h0;
            @(negedge sys_clk);
        end
        repeat (40) @(negedge sys_clk);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #60000;
        err_count++;
        close_out;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        resetn = 1'h1;
        for (i = 0; i < 8; i++) rd(8'h11 + i[7:0], RV[i]);
        wr(8'h12, 8'h02, 8'h02);
        wr(8'h13, 8'h04, 8'h04);
        wr(8'h14, rnd() & 8'hfc, 8'h00);
        wr(8'h17, 8'hfc, 8'h04);
        for (i = 0; i < 16; i++) begin
            wr(8'h11, {5'h00, TC[i][15:13]}, {5'h00, TC[i][15:13]});
            vline(TC[i][12], TC[i][11], TC[i][10:1], TC[i][0], 12);
        end
        st = 254;
        sp = 257;
        wr(8'h12, 8'hfe, 8'hfe);
        wr(8'h13, 8'h01, 8'h01);
        wr(8'h14, 8'hfd, 8'h01);
        wr(8'h11, 8'h01, 8'h01);
        vline(1'h0, 1'h0, 10'h00a, 1'h1, 520);
        wr(8'h12, 8'h00, 8'h00);
        wr(8'h13, 8'h14, 8'h14);
        wr(8'h14, 8'h00, 8'h00);
        hold = 1'h1;
        chk_on = 1'h0;
        vline(1'h0, 1'h0, 10'h00a, 1'h0, 42);
        `CHK(raw_overflow_reg, 1'h1)
        hold = 1'h0;
        repeat (60) @(negedge sys_clk);
        `CHK(raw_valid, 1'h0)
        chk_on = 1'h1;
        vline(1'h0, 1'h0, 10'h00a, 1'h0, 0);
        `CHK(raw_overflow_reg, 1'h0)
        `CHK(dq.size(), 0)
        // a write while the clock enable is low must not land
        @(negedge sys_clk);
        clk_en = 1'h0;
        reg_wr = 1'h1;
        reg_addr = 8'h12;
        reg_wdata = 8'h55;
        @(negedge sys_clk);
        reg_wr = 1'h0;
        clk_en = 1'h1;
        rd(8'h12, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHK(rq.size(), 0)
        close_out;
    end
endmodule
`default_nettype wire
